// >>> rtl/board_test_mode.sv
// board test mode select, identification readout and nand chain outputs
// assumes tester drives test select, request and hold pins asynchronously;
// chain members come straight from the pad inputs, excluded pins never do
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - test select low with request code 0010 enters nand chain mode
// - code is taken at test select fall and held until test select rises
// - test select negated while clk_en is high returns the device to normal operation
// - id code with hold high drives device id high and revision low
// - id code with hold low drives manufacturer id on all 32 bits
// - code 1111 disables any test mode whatever the hold input
// - chain mode floats all outputs but the four grant pins
// - 282 members split into chains of 72, 72, 70 and 68
// - chain mode holds until test select is negated or reset
// - reset, test select and primary suspend status are in no chain
// - chain 0 on grant 0; address 25 first, mgmt active 5, data 54 at 47
module board_test_mode
	import test_mode_pkg::*;
#(
	// arbitrary identification values, not those of any real part
	parameter logic [15:0] DEVICE_ID = 16'h1234,
	parameter logic [7:0]  REV_ID    = 8'h01,
	parameter logic [31:0] MFG_ID    = 32'h5a5a_0001
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire logic                  test_sel_n,
	input  wire logic [3:0]            req_n,
	input  wire logic                  passive_hold_request_n,
	input  wire logic [CHAIN0_LEN-1:0] chain0_in,
	input  wire logic [CHAIN1_LEN-1:0] chain1_in,
	input  wire logic [CHAIN2_LEN-1:0] chain2_in,
	input  wire logic [CHAIN3_LEN-1:0] chain3_in,
	output logic [3:0]                 gnt_chain_n,
	output logic                       gnt_chain_oe,
	output logic                       outputs_float,
	output logic [31:0]                ad_out,
	output logic [31:0]                ad_oe,
	output logic                       test_active,
	output logic [1:0]                 mode
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic        tsel_s1;
		logic        tsel_s2;
		logic        tsel_prev;
		logic [3:0]  req_s1;
		logic [3:0]  req_s2;
		logic        hold_s1;
		logic        hold_s2;
		mode_e       mode;
		logic        float_out;
		logic        gnt_oe;
		logic [31:0] ad_out;
		logic [31:0] ad_oe;
		logic        active;
	} state_s;

	localparam state_s STATE_RST = '{
		tsel_s1:   PIN_HIGH_RST,
		tsel_s2:   PIN_HIGH_RST,
		tsel_prev: PIN_HIGH_RST,
		req_s1:    REQ_SYNC_RST,
		req_s2:    REQ_SYNC_RST,
		hold_s1:   PIN_HIGH_RST,
		hold_s2:   PIN_HIGH_RST,
		mode:      MODE_NORMAL,
		float_out: 1'b0,
		gnt_oe:    1'b0,
		ad_out:    AD_OUT_RST,
		ad_oe:     AD_OE_RST,
		active:    1'b0
	};

	state_s st_ff;
	state_s nxt_st;
	logic   tsel_fall;

	////////////////////////////////////////////////////////////////////////
	// functions

	// reserved codes fall back to normal: safest reading of a tester slip
	function automatic mode_e decode_code(input logic [3:0] code,
	                                      input logic hold_n);
		case (code)
			CODE_NAND: decode_code = MODE_NAND;
			CODE_ID:   decode_code = hold_n ? MODE_IDREV : MODE_MFGID;
			CODE_EXIT: decode_code = MODE_NORMAL;
			default:   decode_code = MODE_NORMAL;
		endcase
	endfunction : decode_code

	////////////////////////////////////////////////////////////////////////
	// next state

	assign tsel_fall = st_ff.tsel_prev & ~st_ff.tsel_s2;

	always_comb begin
		nxt_st = st_ff;
		if (clk_en) begin
			nxt_st.tsel_s1   = test_sel_n;
			nxt_st.tsel_s2   = st_ff.tsel_s1;
			nxt_st.tsel_prev = st_ff.tsel_s2;
			nxt_st.req_s1    = req_n;
			nxt_st.req_s2    = st_ff.req_s1;
			nxt_st.hold_s1   = passive_hold_request_n;
			nxt_st.hold_s2   = st_ff.hold_s1;

			if (st_ff.tsel_s2) begin
				nxt_st.mode = MODE_NORMAL;
			end else if (tsel_fall) begin
				nxt_st.mode = decode_code(st_ff.req_s2, st_ff.hold_s2);
			end else if (st_ff.mode == MODE_IDREV ||
			             st_ff.mode == MODE_MFGID) begin
				// hold picks between the two readouts while the code stands
				nxt_st.mode = st_ff.hold_s2 ? MODE_IDREV : MODE_MFGID;
			end else begin
				nxt_st.mode = st_ff.mode;
			end

			// pin controls follow the new mode on the same edge
			nxt_st.float_out = (nxt_st.mode == MODE_NAND);
			nxt_st.gnt_oe    = (nxt_st.mode == MODE_NAND);
			nxt_st.active    = (nxt_st.mode != MODE_NORMAL);
			case (nxt_st.mode)
				MODE_IDREV: begin
					nxt_st.ad_out = {DEVICE_ID, 8'h00, REV_ID};
					nxt_st.ad_oe  = IDREV_OE_MASK;
				end
				MODE_MFGID: begin
					nxt_st.ad_out = MFG_ID;
					nxt_st.ad_oe  = MFGID_OE_MASK;
				end
				default: begin
					nxt_st.ad_out = AD_OUT_RST;
					nxt_st.ad_oe  = AD_OE_RST;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= STATE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// nand chains
	// the chains must work with both clocks stopped, so their results are
	// combinational from the pads; only the enable comes from a flop.
	// reset, test select and primary suspend status have no chain port.

	nand_chain #(.LEN(CHAIN0_LEN)) u_chain0 (
		.member_in (chain0_in),
		.chain_out (gnt_chain_n[0])
	);

	nand_chain #(.LEN(CHAIN1_LEN)) u_chain1 (
		.member_in (chain1_in),
		.chain_out (gnt_chain_n[1])
	);

	nand_chain #(.LEN(CHAIN2_LEN)) u_chain2 (
		.member_in (chain2_in),
		.chain_out (gnt_chain_n[2])
	);

	nand_chain #(.LEN(CHAIN3_LEN)) u_chain3 (
		.member_in (chain3_in),
		.chain_out (gnt_chain_n[3])
	);

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign gnt_chain_oe  = st_ff.gnt_oe;
	assign outputs_float = st_ff.float_out;
	assign ad_out        = st_ff.ad_out;
	assign ad_oe         = st_ff.ad_oe;
	assign test_active   = st_ff.active;
	assign mode          = st_ff.mode;

	////////////////////////////////////////////////////////////////////////
	// checks

	chk_nand_entry: assert property (
		@(posedge clk) disable iff (rst)
		(clk_en && tsel_fall && st_ff.req_s2 == CODE_NAND)
		|=> (st_ff.mode == MODE_NAND && gnt_chain_oe && outputs_float)
	) else $error("nand code at test select fall did not enter chain mode");

	chk_pin_to_mode: assert property (
		@(posedge clk) disable iff (rst)
		(clk_en && $fell(test_sel_n) && req_n == CODE_NAND)
		##1 (clk_en && !test_sel_n && req_n == CODE_NAND) [*2]
		|=> (mode == MODE_NAND)
	) else $error("chain mode not reached three edges after pin fall");

	chk_leave_negate: assert property (
		@(posedge clk) disable iff (rst)
		(clk_en && st_ff.tsel_s2)
		|=> (mode == MODE_NORMAL && !test_active && ad_oe == AD_OE_RST)
	) else $error("test mode still active after test select negated");

	chk_idrev_drive: assert property (
		@(posedge clk) disable iff (rst)
		(mode == MODE_IDREV)
		|-> (ad_oe == IDREV_OE_MASK && ad_out[31:16] == DEVICE_ID
		     && ad_out[7:0] == REV_ID)
	) else $error("device and revision identifiers not driven");

	chk_mfg_drive: assert property (
		@(posedge clk) disable iff (rst)
		(clk_en && tsel_fall && st_ff.req_s2 == CODE_ID && !st_ff.hold_s2)
		|=> (ad_oe == MFGID_OE_MASK && ad_out == MFG_ID)
	) else $error("manufacturer identifier not driven on id code, hold low");

	chk_exit_code: assert property (
		@(posedge clk) disable iff (rst)
		(clk_en && tsel_fall && st_ff.req_s2 == CODE_EXIT)
		|=> (mode == MODE_NORMAL && !gnt_chain_oe && !outputs_float)
	) else $error("exit code did not return to normal mode");

	chk_float_grant: assert property (
		@(posedge clk) disable iff (rst)
		outputs_float |-> (gnt_chain_oe && ad_oe == AD_OE_RST)
	) else $error("chain mode drives a pin other than the grants");

	chk_nand_hold: assert property (
		@(posedge clk) disable iff (rst)
		(mode == MODE_NAND && !st_ff.tsel_s2 && !tsel_fall)
		|=> (mode == MODE_NAND) [*2]
		or (mode == MODE_NAND ##1 (st_ff.tsel_s2 || tsel_fall))
	) else $error("chain mode left without a new mode or reset");

	chk_chain_ones: assert property (
		@(posedge clk) disable iff (rst)
		(&chain0_in && &chain1_in && &chain2_in && &chain3_in)
		|-> (gnt_chain_n == 4'hf)
	) else $error("all-high members do not give high chain outputs");

	chk_chain_first: assert property (
		@(posedge clk) disable iff (rst)
		(chain0_in[CH0_HOST_ADDR25] == 1'b0
		 && &chain0_in[CHAIN0_LEN-1:CH0_HOST_ADDR25+1])
		|-> (gnt_chain_n[0] == 1'b0)
	) else $error("first element of chain 0 does not toggle grant 0");

	// a member only reaches the grant when the stage before it is high
	// and every later member is high, so the prefix is 0,1,1,1,1
	chk_chain_mgmt: assert property (
		@(posedge clk) disable iff (rst)
		(!chain0_in[CH0_HOST_ADDR25] && &chain0_in[CH0_SYS_MGMT-1:1]
		 && &chain0_in[CHAIN0_LEN-1:CH0_SYS_MGMT+1]
		 && $changed(chain0_in[CH0_SYS_MGMT])
		 && $stable(chain0_in[CH0_SYS_MGMT-1:0])
		 && $stable(chain0_in[CHAIN0_LEN-1:CH0_SYS_MGMT+1]))
		|-> $changed(gnt_chain_n[0])
	) else $error("single member change did not toggle grant 0");

	cov_nand: cover property (
		@(posedge clk) disable iff (rst) $rose(gnt_chain_oe));
	cov_idrev: cover property (
		@(posedge clk) disable iff (rst) mode == MODE_IDREV);
	cov_mfgid: cover property (
		@(posedge clk) disable iff (rst) mode == MODE_MFGID);
	cov_exit: cover property (
		@(posedge clk) disable iff (rst)
		clk_en && tsel_fall && st_ff.req_s2 == CODE_EXIT);

endmodule : board_test_mode

`default_nettype wire

// >>> inc/test_mode_pkg.sv
// constants shared by the board test mode controller and its chains
// assumes pin levels arrive raw; codes are pin levels, active low as printed
package test_mode_pkg;

	// request pin codes, REQ[3:0] pin levels at the test select fall
	localparam logic [3:0]  CODE_NAND       = 4'h2;
	localparam logic [3:0]  CODE_ID         = 4'he;
	localparam logic [3:0]  CODE_EXIT       = 4'hf;

	// chain lengths
	localparam int          CHAIN0_LEN      = 72;
	localparam int          CHAIN1_LEN      = 72;
	localparam int          CHAIN2_LEN      = 70;
	localparam int          CHAIN3_LEN      = 68;
	localparam int          CHAIN_TOTAL     = 282;
	localparam int          CHAIN_COUNT     = 4;

	// fixed element positions in chain 0
	localparam int          CH0_HOST_ADDR25 = 0;
	localparam int          CH0_SYS_MGMT    = 5;
	localparam int          CH0_HOST_DATA54 = 47;

	// address/data drive masks in the identification modes
	localparam logic [31:0] IDREV_OE_MASK   = 32'hffff_00ff;
	localparam logic [31:0] MFGID_OE_MASK   = 32'hffff_ffff;

	// values after reset
	localparam logic [31:0] AD_OUT_RST      = 32'h0000_0000;
	localparam logic [31:0] AD_OE_RST       = 32'h0000_0000;
	localparam logic [3:0]  REQ_SYNC_RST    = 4'hf;
	localparam logic        PIN_HIGH_RST    = 1'b1;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_NAND   = 2'b01,
		MODE_IDREV  = 2'b10,
		MODE_MFGID  = 2'b11
	} mode_e;

endpackage : test_mode_pkg

// >>> rtl/nand_chain.sv
// one nand chain: each stage nands its member pin with the stage before
// assumes the members are raw pin levels; purely combinational, no clock
`timescale 1ns/1ps
`default_nettype none

module nand_chain #(
	parameter int LEN = 8
) (
	input  wire logic [LEN-1:0] member_in,
	output logic                chain_out
);

	logic [LEN-1:0] stage;

	// first stage sees a constant high in place of a previous stage
	assign stage[0] = ~member_in[0];

	for (genvar i = 1; i < LEN; i++) begin : g_stage
		assign stage[i] = ~(member_in[i] & stage[i-1]);
	end

	assign chain_out = stage[LEN-1];

endmodule : nand_chain

`default_nettype wire

// >>> verification/ate_model.sv
// board tester model: drives test select, request pins, hold pin, clock run
// assumes bench commands change at the rising edge of clk
`timescale 1ns/1ps
`default_nettype none

module ate_model (
	input  wire logic       clk,
	input  wire logic       cmd_sel,
	input  wire logic [3:0] cmd_code,
	input  wire logic       cmd_hold,
	input  wire logic       cmd_run,
	output logic            test_sel_n,
	output logic [3:0]      req_n,
	output logic            hold_n,
	output logic            clk_en,
	output logic            suspend_status_n
);
	// request lines carry noise while select is negated; it must be ignored
	always @(posedge clk) begin
		test_sel_n       <= ~cmd_sel;
		req_n            <= cmd_sel ? cmd_code : 4'($urandom());
		hold_n           <= cmd_hold;
		clk_en           <= cmd_run;
		suspend_status_n <= 1'b1;
	end
endmodule : ate_model

`default_nettype wire

// >>> verification/board_test_mode_nand_chain_tb_top.sv
// bench for the board test mode block against a behavioural model
// assumes the tester model drives the select pins; bench drives chain pads
`timescale 1ns/1ps
`default_nettype none

module board_test_mode_nand_chain_tb_top;
	import test_mode_pkg::*;
	// arbitrary identification values
	localparam logic [15:0] DEV = 16'h3c5a;
	localparam logic [7:0]  REV = 8'h07;
	localparam logic [31:0] MFG = 32'h0bad_cafe;

	logic                  clk, rst, cmd_sel, cmd_hold, cmd_run;
	logic [3:0]            cmd_code, req_n, gnt_chain_n;
	logic                  test_sel_n, hold_n, clk_en;
	logic                  gnt_chain_oe, outputs_float, test_active;
	logic [31:0]           ad_out, ad_oe;
	logic [1:0]            mode;
	logic [CHAIN0_LEN-1:0] c0;
	logic [CHAIN1_LEN-1:0] c1;
	logic [CHAIN2_LEN-1:0] c2;
	logic [CHAIN3_LEN-1:0] c3;
	logic                  susp_n;
	logic [3:0]            code;
	int                    failures, checked, r;

	ate_model u_ate_model (.clk(clk), .cmd_sel(cmd_sel), .cmd_code(cmd_code),
		.cmd_hold(cmd_hold), .cmd_run(cmd_run), .test_sel_n(test_sel_n),
		.req_n(req_n), .hold_n(hold_n), .clk_en(clk_en),
		.suspend_status_n(susp_n));

	board_test_mode #(.DEVICE_ID(DEV), .REV_ID(REV), .MFG_ID(MFG))
	u_board_test_mode (.clk(clk), .rst(rst), .clk_en(clk_en),
		.test_sel_n(test_sel_n), .req_n(req_n),
		.passive_hold_request_n(hold_n), .chain0_in(c0), .chain1_in(c1),
		.chain2_in(c2), .chain3_in(c3), .gnt_chain_n(gnt_chain_n),
		.gnt_chain_oe(gnt_chain_oe), .outputs_float(outputs_float),
		.ad_out(ad_out), .ad_oe(ad_oe), .test_active(test_active),
		.mode(mode));

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [31:0] e,
		input logic [31:0] g);
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", what, e, g);
			failures++;
		end
		checked++;
	endtask : check

	function automatic logic [1:0] exp_mode(input logic [3:0] c, input logic h);
		if (c == CODE_NAND)
			return MODE_NAND;
		if (c == CODE_ID)
			return h ? MODE_IDREV : MODE_MFGID;
		return MODE_NORMAL;
	endfunction : exp_mode

	// reference chain: first stage inverts, later stages nand with previous
	function automatic logic nand_ref(input logic [71:0] v, input int n);
		logic s;
		s = ~v[0];
		for (int k = 1; k < n; k++)
			s = ~(v[k] & s);
		return s;
	endfunction : nand_ref

	task automatic check_outputs(input logic [1:0] m);
		logic [31:0] eo, ed;
		eo = (m == MODE_IDREV) ? 32'hffff_00ff :
			(m == MODE_MFGID) ? 32'hffff_ffff : 32'h0000_0000;
		ed = (m == MODE_IDREV) ? {DEV, 8'h00, REV} : MFG;
		check("mode", 32'(m), 32'(mode));
		check("test_active", 32'(m != MODE_NORMAL), 32'(test_active));
		check("gnt_oe", 32'(m == MODE_NAND), 32'(gnt_chain_oe));
		check("float", 32'(m == MODE_NAND), 32'(outputs_float));
		check("ad_oe", eo, ad_oe);
		check("ad_out", ed & eo, ad_out & eo);
	endtask : check_outputs

	task automatic chk_chain;
		check("gnt", {28'h0, nand_ref(72'(c3), CHAIN3_LEN),
			nand_ref(72'(c2), CHAIN2_LEN), nand_ref(c1, CHAIN1_LEN),
			nand_ref(c0, CHAIN0_LEN)}, 32'(gnt_chain_n));
	endtask : chk_chain

	// negate, confirm normal, then select with a fresh code
	task automatic enter(input logic [3:0] c, input logic h);
		cmd_sel <= 1'b0;
		repeat (4) @(posedge clk);
		#1 check_outputs(MODE_NORMAL);
		repeat (2) @(posedge clk);
		cmd_code <= c;
		cmd_hold <= h;
		cmd_sel  <= 1'b1;
		repeat (4) @(posedge clk);
		#1 check_outputs(exp_mode(c, h));
	endtask : enter

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#100us;
		failures++;
		stop_test();
	end

	initial begin
		failures = 0;
		checked  = 0;
		rst      = 1'b1;
		{cmd_sel, cmd_hold, cmd_run, cmd_code} = 7'h3f;
		{c0, c1, c2, c3} = '1;
		void'($urandom(90883));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// only the three codes nand, id and exit are ever presented
		for (int i = 0; i < 32; i++) begin
			r    = $urandom_range(5);
			code = (r < 2) ? CODE_NAND : (r < 4) ? CODE_ID : CODE_EXIT;
			enter(code, r[0]);
		end
		// hold pin is followed live in the id modes
		enter(CODE_ID, 1'b1);
		cmd_hold <= 1'b0;
		repeat (4) @(posedge clk);
		#1 check_outputs(MODE_MFGID);
		enter(CODE_NAND, 1'b1);
		// code changes with select held low are ignored
		cmd_code <= CODE_EXIT;
		repeat (6) @(posedge clk);
		#1 check_outputs(MODE_NAND);
		cmd_run <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk_chain();
		for (int p = 0; p < 4; p++) begin
			@(posedge clk);
			c0[(p == 3) ? 71 : (p == 2) ? 47 : p * 5] <= 1'b0;
			@(negedge clk) chk_chain();
		end
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			c0 <= 72'({$urandom(), $urandom(), $urandom()});
			c1 <= 72'({$urandom(), $urandom(), $urandom()});
			c2 <= 70'({$urandom(), $urandom(), $urandom()});
			c3 <= 68'({$urandom(), $urandom(), $urandom()});
			@(negedge clk) chk_chain();
		end
		check_outputs(MODE_NAND);
		// reset while in chain mode returns to normal
		cmd_run <= 1'b1;
		rst     <= 1'b1;
		@(posedge clk);
		#1 check_outputs(MODE_NORMAL);
		stop_test();
	end
endmodule : board_test_mode_nand_chain_tb_top

`default_nettype wire
